/* rtl/main_clock_rtc_beeper.sv */
// main clock controller: cpu prescaler, clock out, time base and tone output
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

// How it works
// - clock_out_select drives clock onto clkout pin
// - clock-out stops during timed halt mode
// - slow mode divides by 2,4,8,16
// - slow_mode_select zero gives undivided clock
// - time base periods 16000 to 200000 cycles
// - new timebase_select applies at period end
// - period end sets flag; register read clears
// - interrupt when flag and enable, global mask
// - halt with irq enable enters timed halt
// - time base wakes wait, timed halt only
// - full halt freezes counter and registers
// - timed halt counts, registers frozen
// - wait mode leaves everything running
// - beep_sel picks off or three tones
// - tone keeps running in timed halt
// - both registers reset to zero
module main_clock_rtc_beeper (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire clk_ctrl_pkg::bus_req_type bus_req,
  output logic [7:0]                     rdata,
  input  wire logic                      halt_req,
  input  wire logic                      wait_req,
  input  wire logic                      ext_wake,
  input  wire logic                      global_irq_mask,
  output logic                           cpu_clk_en,
  output logic                           clkout_port_pin,
  output logic                           clkout_oe,
  output logic                           tone_port_pin,
  output logic                           tone_oe,
  output logic                           timebase_irq,
  output logic                           wake_evt,
  output clk_ctrl_pkg::power_mode_type   power_mode
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [17:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'h0:    tb_period = clk_ctrl_pkg::TB_PERIOD_0;
      2'h1:    tb_period = clk_ctrl_pkg::TB_PERIOD_1;
      2'h2:    tb_period = clk_ctrl_pkg::TB_PERIOD_2;
      default: tb_period = clk_ctrl_pkg::TB_PERIOD_3;
    endcase
  endfunction

  function automatic logic [13:0] tone_half(input logic [1:0] sel);
    case (sel)
      2'h1:    tone_half = clk_ctrl_pkg::TONE_HALF_1;
      2'h2:    tone_half = clk_ctrl_pkg::TONE_HALF_2;
      default: tone_half = clk_ctrl_pkg::TONE_HALF_3;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  clk_ctrl_pkg::ctrl_type       ctrl_r, ctrl_nxt;
  logic                         flag_r, flag_nxt;
  logic [1:0]                   beep_r, beep_nxt;
  logic [7:0]                   rdata_r, rdata_nxt;
  clk_ctrl_pkg::power_mode_type mode_r, mode_nxt;
  logic [17:0]                  tb_cnt_r, tb_cnt_nxt;
  logic [1:0]                   tb_act_r, tb_act_nxt;
  logic [3:0]                   pre_cnt_r, pre_cnt_nxt;
  logic [13:0]                  tone_cnt_r, tone_cnt_nxt;
  logic                         tone_r, tone_nxt;
  logic                         clkout_r, clkout_nxt;
  logic                         cpu_en_r, cpu_en_nxt;

  logic                         regs_frozen;
  logic                         tb_run;
  logic                         tb_end;
  logic                         wr_main;
  logic                         wr_tone;
  logic                         rd_main;
  logic                         irq_req;
  logic [7:0]                   main_view;

  // freeze conditions per power mode
  assign regs_frozen = (mode_r == clk_ctrl_pkg::PWR_TIMED_HALT) ||
                       (mode_r == clk_ctrl_pkg::PWR_HALT);
  assign tb_run  = (mode_r != clk_ctrl_pkg::PWR_HALT);
  assign tb_end  = tb_run && (tb_cnt_r == 18'h00000);
  assign wr_main = bus_req.wr && !regs_frozen &&
                   bus_req.addr == clk_ctrl_pkg::MAIN_CTRL_STATUS_ADDR;
  assign wr_tone = bus_req.wr && !regs_frozen &&
                   bus_req.addr == clk_ctrl_pkg::TONE_CTRL_ADDR;
  assign rd_main = bus_req.rd &&
                   bus_req.addr == clk_ctrl_pkg::MAIN_CTRL_STATUS_ADDR;
  // the cpu global mask gates the request onto the line
  assign irq_req = flag_r && ctrl_r.timebase_irq_en;
  assign main_view = {ctrl_r, flag_r};

  // ****************************************
  // registers and readback
  // ****************************************
  // a read-modify-write by software would clear the flag
  always_comb begin
    ctrl_nxt  = ctrl_r;
    beep_nxt  = beep_r;
    flag_nxt  = flag_r;
    rdata_nxt = 8'h00;
    if (wr_main) begin
      ctrl_nxt = bus_req.wdata[clk_ctrl_pkg::CLOCK_OUT_BIT:
                               clk_ctrl_pkg::IRQ_EN_BIT];
    end
    if (wr_tone) begin
      // reserved upper bits are dropped, read back zero
      beep_nxt = bus_req.wdata[clk_ctrl_pkg::BEEP_HI:clk_ctrl_pkg::BEEP_LO];
    end
    if (bus_req.rd) begin
      if (bus_req.addr == clk_ctrl_pkg::MAIN_CTRL_STATUS_ADDR) begin
        rdata_nxt = main_view;
      end else if (bus_req.addr == clk_ctrl_pkg::TONE_CTRL_ADDR) begin
        rdata_nxt = {6'h00, beep_r};
      end
    end
    // set wins over the read clear so no period is lost
    if (rd_main) begin
      flag_nxt = 1'b0;
    end
    if (tb_end) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r  <= '0;
      beep_r  <= 2'h0;
      flag_r  <= 1'b0;
      rdata_r <= clk_ctrl_pkg::REG_RESET;
    end else begin
      ctrl_r  <= ctrl_nxt;
      beep_r  <= beep_nxt;
      flag_r  <= flag_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // power mode tracking
  // ****************************************
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      clk_ctrl_pkg::PWR_RUN: begin
        if (halt_req) begin
          mode_nxt = ctrl_r.timebase_irq_en ?
                     clk_ctrl_pkg::PWR_TIMED_HALT :
                     clk_ctrl_pkg::PWR_HALT;
        end else if (wait_req) begin
          mode_nxt = clk_ctrl_pkg::PWR_WAIT;
        end
      end
      clk_ctrl_pkg::PWR_WAIT: begin
        if (ext_wake || (irq_req && !global_irq_mask)) begin
          mode_nxt = clk_ctrl_pkg::PWR_RUN;
        end
      end
      clk_ctrl_pkg::PWR_TIMED_HALT: begin
        if (ext_wake || (irq_req && !global_irq_mask)) begin
          mode_nxt = clk_ctrl_pkg::PWR_RUN;
        end
      end
      clk_ctrl_pkg::PWR_HALT: begin
        // only an outside halt-capable interrupt ends full halt
        if (ext_wake) begin
          mode_nxt = clk_ctrl_pkg::PWR_RUN;
        end
      end
      default: mode_nxt = clk_ctrl_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= clk_ctrl_pkg::PWR_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ****************************************
  // time base divider
  // ****************************************
  // selection latched only at reload to avoid a time shift
  always_comb begin
    tb_cnt_nxt = tb_cnt_r;
    tb_act_nxt = tb_act_r;
    if (tb_end) begin
      tb_act_nxt = ctrl_r.timebase_select;
      tb_cnt_nxt = tb_period(ctrl_r.timebase_select) - 18'h1;
    end else if (tb_run) begin
      tb_cnt_nxt = tb_cnt_r - 18'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tb_cnt_r <= clk_ctrl_pkg::TB_PERIOD_0 - 18'h1;
      tb_act_r <= 2'h0;
    end else begin
      tb_cnt_r <= tb_cnt_nxt;
      tb_act_r <= tb_act_nxt;
    end
  end

  // ****************************************
  // cpu prescaler and clock out
  // ****************************************
  // cpu clock is an enable pulse; clock out toggles at the enable rate
  always_comb begin
    pre_cnt_nxt = pre_cnt_r + 4'h1;
    cpu_en_nxt  = 1'b1;
    if (ctrl_r.slow_mode_select) begin
      case (ctrl_r.cpu_prescale_sel)
        2'h0:    cpu_en_nxt = (pre_cnt_r[0]   == 1'b1);
        2'h1:    cpu_en_nxt = (pre_cnt_r[1:0] == 2'h3);
        2'h2:    cpu_en_nxt = (pre_cnt_r[2:0] == 3'h7);
        default: cpu_en_nxt = (pre_cnt_r      == 4'hF);
      endcase
    end
    clkout_nxt = clkout_r;
    if (mode_r == clk_ctrl_pkg::PWR_TIMED_HALT ||
        mode_r == clk_ctrl_pkg::PWR_HALT) begin
      clkout_nxt = 1'b0;
    end else if (ctrl_r.clock_out_select) begin
      clkout_nxt = cpu_en_nxt ? ~clkout_r : clkout_r;
    end else begin
      clkout_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt_r <= 4'h0;
      cpu_en_r  <= 1'b1;
      clkout_r  <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      cpu_en_r  <= cpu_en_nxt;
      clkout_r  <= clkout_nxt;
    end
  end

  // ****************************************
  // tone generator
  // ****************************************
  // keeps running in wait and timed halt; stops only in full halt
  always_comb begin
    tone_cnt_nxt = tone_cnt_r;
    tone_nxt     = tone_r;
    if (beep_r == 2'h0) begin
      tone_cnt_nxt = 14'h0000;
      tone_nxt     = 1'b0;
    end else if (mode_r != clk_ctrl_pkg::PWR_HALT) begin
      if (tone_cnt_r >= tone_half(beep_r) - 14'h1) begin
        tone_cnt_nxt = 14'h0000;
        tone_nxt     = ~tone_r;
      end else begin
        tone_cnt_nxt = tone_cnt_r + 14'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tone_cnt_r <= 14'h0000;
      tone_r     <= 1'b0;
    end else begin
      tone_cnt_r <= tone_cnt_nxt;
      tone_r     <= tone_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata           = rdata_r;
  assign cpu_clk_en      = cpu_en_r;
  assign clkout_port_pin = clkout_r;
  assign clkout_oe       = ctrl_r.clock_out_select;
  assign tone_port_pin   = tone_r;
  assign tone_oe         = (beep_r != 2'h0);
  assign timebase_irq    = irq_req && !global_irq_mask;
  assign wake_evt        = (mode_r != mode_nxt) &&
                           (mode_nxt == clk_ctrl_pkg::PWR_RUN);
  assign power_mode      = mode_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_halt_with_irq;
    halt_req && ctrl_r.timebase_irq_en &&
    mode_r == clk_ctrl_pkg::PWR_RUN;
  endsequence

  a_halt_mode_entry: assert property (
    @(posedge clock) disable iff (rst)
    s_halt_with_irq |=> mode_r == clk_ctrl_pkg::PWR_TIMED_HALT)
    else $error("timed halt not entered");

  a_flag_set_end: assert property (
    @(posedge clock) disable iff (rst)
    tb_end |=> flag_r)
    else $error("flag not set at period end");

  a_flag_read_clear: assert property (
    @(posedge clock) disable iff (rst)
    rd_main && !tb_end |=> !flag_r)
    else $error("flag not cleared by read");

  a_irq_gate: assert property (
    @(posedge clock) disable iff (rst)
    timebase_irq == (flag_r && ctrl_r.timebase_irq_en && !global_irq_mask))
    else $error("interrupt gating wrong");

  a_halt_freeze: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_HALT && mode_nxt == mode_r
    |=> $stable(tb_cnt_r) && $stable(ctrl_r))
    else $error("counter moved in halt");

  a_timed_halt_count: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_TIMED_HALT && !tb_end
    |=> tb_cnt_r == $past(tb_cnt_r) - 18'h1 && $stable(ctrl_r))
    else $error("timed halt counting wrong");

  a_clkout_stop: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_TIMED_HALT |=> !clkout_port_pin)
    else $error("clock out toggles in timed halt");

  a_period_reload: assert property (
    @(posedge clock) disable iff (rst)
    tb_end |=> tb_cnt_r == tb_period(tb_act_r) - 18'h1)
    else $error("period reload wrong");

  a_normal_cpu_clk: assert property (
    @(posedge clock) disable iff (rst)
    !ctrl_r.slow_mode_select [*2] |-> cpu_clk_en)
    else $error("cpu clock divided in normal mode");

  a_no_halt_wake: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_HALT && !ext_wake
    |=> mode_r == clk_ctrl_pkg::PWR_HALT)
    else $error("time base woke full halt");

  // a drifting tone pin in full halt would glitch the buzzer on wake
  a_tone_halt_hold: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_HALT && mode_nxt == mode_r
    |=> $stable(tone_port_pin))
    else $error("tone moved in full halt");

  a_tone_timed_run: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_TIMED_HALT && beep_r != 2'h0
    |=> tone_cnt_r != $past(tone_cnt_r))
    else $error("tone stopped in timed halt");

  a_wait_count_run: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_WAIT |=> tb_cnt_r != $past(tb_cnt_r))
    else $error("time base stopped in wait");

  a_tone_off: assert property (
    @(posedge clock) disable iff (rst)
    beep_r == 2'h0 |=> !tone_port_pin)
    else $error("tone pin active while off");

  a_timed_halt_wake: assert property (
    @(posedge clock) disable iff (rst)
    mode_r == clk_ctrl_pkg::PWR_TIMED_HALT && timebase_irq
    |=> mode_r == clk_ctrl_pkg::PWR_RUN)
    else $error("time base did not wake timed halt");

endmodule

/* include/clk_ctrl_pkg.sv */
// package: register map, field layout and timing constants of the clock controller
package clk_ctrl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] MAIN_CTRL_STATUS_ADDR = 8'h2C;
  localparam logic [7:0] TONE_CTRL_ADDR        = 8'h2D;
  localparam logic [7:0] REG_RESET             = 8'h00;

  // main_ctrl_status and tone control field positions
  localparam int CLOCK_OUT_BIT   = 7;
  localparam int PRESCALE_HI     = 6;
  localparam int PRESCALE_LO     = 5;
  localparam int SLOW_MODE_BIT   = 4;
  localparam int TIMEBASE_HI     = 3;
  localparam int TIMEBASE_LO     = 2;
  localparam int IRQ_EN_BIT      = 1;
  localparam int FLAG_BIT        = 0;
  localparam int BEEP_HI         = 1;
  localparam int BEEP_LO         = 0;

  // ****************************************
  // timing constants (osc_half_clock cycles)
  // ****************************************
  localparam logic [17:0] TB_PERIOD_0 = 18'h03E80; // 16000
  localparam logic [17:0] TB_PERIOD_1 = 18'h07D00; // 32000
  localparam logic [17:0] TB_PERIOD_2 = 18'h13880; // 80000
  localparam logic [17:0] TB_PERIOD_3 = 18'h30D40; // 200000

  // tone half periods: 8 MHz / (2 * half) gives ~2k, ~1k, ~500 Hz
  localparam logic [13:0] TONE_HALF_1 = 14'h07D0; // 2000
  localparam logic [13:0] TONE_HALF_2 = 14'h0FA0; // 4000
  localparam logic [13:0] TONE_HALF_3 = 14'h1F40; // 8000

  // power modes as seen by the clock controller
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_WAIT,
    PWR_TIMED_HALT,
    PWR_HALT
  } power_mode_type;

  // software-visible control fields
  typedef struct packed {
    logic       clock_out_select;
    logic [1:0] cpu_prescale_sel;
    logic       slow_mode_select;
    logic [1:0] timebase_select;
    logic       timebase_irq_en;
  } ctrl_type;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

endpackage

/* sim/tone_listener.sv */
// partner model: external device listening on the tone pin
`timescale 1ns/1ps

module tone_listener (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        tone_port_pin,
  output logic [31:0]      last_half
);
  logic        prev_r;
  logic [31:0] run_r;

  // width of the last tone half period, in clock cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_r    <= 1'b0;
      run_r     <= 32'h0;
      last_half <= 32'h0;
    end else begin
      prev_r <= tone_port_pin;
      if (tone_port_pin !== prev_r) begin
        last_half <= run_r + 32'h1;
        run_r     <= 32'h0;
      end else begin
        run_r <= run_r + 32'h1;
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// testbench: register, prescaler, time base, tone and power mode checks
`timescale 1ns/1ps

module tb_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic                         clock;
  logic                         rst;
  clk_ctrl_pkg::bus_req_type    bus_req;
  logic [7:0]                   rdata;
  logic                         halt_req;
  logic                         wait_req;
  logic                         ext_wake;
  logic                         global_irq_mask;
  logic                         cpu_clk_en;
  logic                         clkout_port_pin;
  logic                         clkout_oe;
  logic                         tone_port_pin;
  logic                         tone_oe;
  logic                         timebase_irq;
  logic                         wake_evt;
  clk_ctrl_pkg::power_mode_type power_mode;
  logic [31:0]                  half;
  logic [31:0]                  cyc;
  logic [31:0]                  t1;
  logic [31:0]                  t2;
  logic [31:0]                  t3;
  logic [31:0]                  en_n;
  logic [31:0]                  rise_n;
  int                           n_mismatch;
  int                           checks;

  main_clock_rtc_beeper dut (.clock(clock), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .halt_req(halt_req), .wait_req(wait_req),
    .ext_wake(ext_wake), .global_irq_mask(global_irq_mask),
    .cpu_clk_en(cpu_clk_en), .clkout_port_pin(clkout_port_pin),
    .clkout_oe(clkout_oe), .tone_port_pin(tone_port_pin),
    .tone_oe(tone_oe), .timebase_irq(timebase_irq), .wake_evt(wake_evt),
    .power_mode(power_mode));

  tone_listener listener (.clock(clock), .rst(rst),
    .tone_port_pin(tone_port_pin), .last_half(half));

  // ****************************************
  // clock, cycle count and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) cyc <= rst ? 32'h0 : cyc + 32'h1;

  // whole run is about 65000 cycles, so this leaves ample slack
  initial begin
    #4000000;
    n_mismatch++;
    summarize();
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // one-cycle power request or wake pulse
  task automatic req(input logic h, input logic w, input logic x);
    @(posedge clock);
    halt_req <= h;
    wait_req <= w;
    ext_wake <= x;
    @(posedge clock);
    halt_req <= 1'b0;
    wait_req <= 1'b0;
    ext_wake <= 1'b0;
    #1;
  endtask

  // counts cpu enables and clock-out rises over n cycles
  task automatic count(input int n);
    logic p;
    en_n = 0;
    rise_n = 0;
    // step past the edge so the first sample is the settled pin
    #1;
    p = clkout_port_pin;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (cpu_clk_en === 1'b1) en_n++;
      if (clkout_port_pin === 1'b1 && p === 1'b0) rise_n++;
      p = clkout_port_pin;
    end
  endtask

  task automatic wait_irq(output logic [31:0] t);
    for (int i = 0; i < 33000; i++) begin
      @(posedge clock);
      #1;
      if (timebase_irq === 1'b1) break;
    end
    t = cyc;
    check(timebase_irq, 1'b1);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    bus_req = '0;
    halt_req = 1'b0;
    wait_req = 1'b0;
    ext_wake = 1'b0;
    global_irq_mask = 1'b0;
    n_mismatch = 0;
    checks = 0;
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(8'h2C, 8'h00);
    rd(8'h2D, 8'h00);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h00);
    wr(8'h2D, 8'h01);
    rd(8'h2D, 8'h01);
    check(tone_oe, 1'b1);
    // every prescale code, then slow mode off
    for (int k = 0; k < 5; k++) begin
      wr(8'h2C, (k < 4) ? (8'h92 | 8'(k << 5)) : 8'h82);
      repeat (4) @(posedge clock);
      count(64);
      check(en_n, 32'(64 >> ((k < 4) ? k + 1 : 0)));
      check(rise_n, 32'(32 >> ((k < 4) ? k + 1 : 0)));
    end
    check(clkout_oe, 1'b1);
    rd(8'h2C, 8'h82);
    wr(8'h2C, 8'h02);
    count(16);
    check({clkout_oe, rise_n[3:0]}, 5'h00);
    // time base periods, tone codes run meanwhile
    wait_irq(t1);
    rd(8'h2C, 8'h03);
    rd(8'h2C, 8'h02);
    check(timebase_irq, 1'b0);
    check(half, 32'd2000);
    wr(8'h2D, 8'h02);
    wr(8'h2C, 8'h86);
    wait_irq(t2);
    check(t2 - t1, 32'd16000);
    rd(8'h2C, 8'h87);
    check(half, 32'd4000);
    wr(8'h2D, 8'h03);
    req(1'b1, 1'b0, 1'b0);
    check(power_mode, clk_ctrl_pkg::PWR_TIMED_HALT);
    wr(8'h2D, 8'h00);
    count(16);
    check({clkout_port_pin, rise_n[3:0]}, 5'h00);
    check(tone_oe, 1'b1);
    wait_irq(t3);
    check(t3 - t2, 32'd32000);
    check(wake_evt, 1'b1);
    @(posedge clock);
    #1 check(power_mode, clk_ctrl_pkg::PWR_RUN);
    check(wake_evt, 1'b0);
    check(half, 32'd8000);
    rd(8'h2D, 8'h03);
    @(posedge clock);
    global_irq_mask <= 1'b1;
    @(posedge clock);
    #1 check(timebase_irq, 1'b0);
    @(posedge clock);
    global_irq_mask <= 1'b0;
    @(posedge clock);
    #1 check(timebase_irq, 1'b1);
    rd(8'h2C, 8'h87);
    rd(8'h2C, 8'h86);
    // full halt needs an outside wake
    wr(8'h2C, 8'h04);
    req(1'b1, 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    #1 check(power_mode, clk_ctrl_pkg::PWR_HALT);
    req(1'b0, 1'b0, 1'b1);
    check(power_mode, clk_ctrl_pkg::PWR_RUN);
    // wait mode leaves the prescaler running
    wr(8'h2C, 8'h84);
    req(1'b0, 1'b1, 1'b0);
    check(power_mode, clk_ctrl_pkg::PWR_WAIT);
    count(16);
    check(en_n, 32'd16);
    check(rise_n, 32'd8);
    req(1'b0, 1'b0, 1'b1);
    check(power_mode, clk_ctrl_pkg::PWR_RUN);
    summarize();
  end
endmodule
